// file: logic/uatx_top.sv
// Summary of operation
// - Five character modes, including parity and address
// - NRZ output, idles at mark
// - Start, 7/8 data, optional ninth, stop
// - Stop bits one, one and half, two
// - Bit period from 16-bit divisor, multiplier
// - Data sent least significant bit first
// - Format and baud shared with receiver
// - Hardware computes and inserts parity bit
// - Shifter hidden, loads only from buffer
// - Drive pin while busy, release when idle if direction set
// - Pin level kept when direction cleared
// - Buffer free flag when enabled and empty
// - Buffer write starts; idle shifter loads at once
// - Queued character loads at stop start
// - Next start follows last stop, no gap
// - Polarity change reaches pin immediately
// - Serial output also feeds internal peripherals
// - Seven-bit mode drops most significant bit
// - Code 0011 even, 0010 odd parity
// - Polarity resets zero; one inverts output
// - Shifter empty flag tracks idle shifter and empty buffer
//
// The register addresses and strobed register access were chosen for this implementation.
`default_nettype none
`include "uatx_params.svh"

module uatx_top
	import uatx_pkg::*;
#(
	parameter int DIV_W = 16,
	parameter int ADDR_W = 4
) (
	input wire logic mclk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [ADDR_W-1:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic port_direction_control, // 1 = pin input when idle
	input wire logic port_out_latch, // port latch level when idle
	output logic tx_pin_o, // pin output level
	output logic tx_pin_oe, // pin output enable
	output logic tx_internal, // serial output to internal peripherals
	output logic transmit_buffer_free_flag, // buffer can take a character
	output logic shifter_empty_flag, // shifter empty and idle
	output logic [3:0] mode_code, // shared format for the receiver
	output logic [DIV_W-1:0] baud_divisor_pair, // shared baud divisor
	output logic baud_multiplier_bit // shared multiplier
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] control_reg_zero_q;
	logic [7:0] control_reg_one_q;
	logic [7:0] control_reg_two_q;
	logic [DIV_W-1:0] baud_q;
	logic [7:0] transmit_buffer_reg_q;
	logic buf_full_q;
	logic [7:0] rdata_q;

	wire transmit_enable_bit = control_reg_zero_q[`UATX_C0_TRANSMIT_ENABLE_BIT];
	wire periph_on = control_reg_one_q[`UATX_C1_ON];
	wire transmit_polarity_bit = control_reg_two_q[`UATX_C2_TRANSMIT_POLARITY_BIT];
	wire [1:0] stop_sel = control_reg_two_q[`UATX_C2_STP_LO +: 2];
	wire [3:0] mode = control_reg_zero_q[3:0];

	wire wr_ctrl0 = reg_wr && (reg_addr == ADDR_W'(`UATX_OFF_CTRL0));
	wire wr_ctrl1 = reg_wr && (reg_addr == ADDR_W'(`UATX_OFF_CTRL1));
	wire wr_ctrl2 = reg_wr && (reg_addr == ADDR_W'(`UATX_OFF_CTRL2));
	wire wr_baudl = reg_wr && (reg_addr == ADDR_W'(`UATX_OFF_BAUDL));
	wire wr_baudh = reg_wr && (reg_addr == ADDR_W'(`UATX_OFF_BAUDH));
	wire wr_txbuf = reg_wr && (reg_addr == ADDR_W'(`UATX_OFF_TXBUF));

	// ----------------------------------------------------------------
	// Shared format and baud
	// ----------------------------------------------------------------
	// The receiver reads the same copies, so the two paths cannot disagree
	assign mode_code = mode;
	assign baud_divisor_pair = baud_q;
	assign baud_multiplier_bit = control_reg_zero_q[`UATX_C0_BRGS];

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			control_reg_zero_q <= `UATX_RST_CTRL0;
			control_reg_one_q <= `UATX_RST_CTRL1;
			control_reg_two_q <= `UATX_RST_CTRL2;
		end else begin
			if (wr_ctrl0) control_reg_zero_q <= reg_wdata;
			if (wr_ctrl1) control_reg_one_q <= reg_wdata;
			if (wr_ctrl2) control_reg_two_q <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			baud_q <= `UATX_RST_BAUD;
		end else begin
			if (wr_baudl) baud_q[7:0] <= reg_wdata;
			if (wr_baudh) baud_q[DIV_W-1:8] <= reg_wdata[DIV_W-9:0];
		end
	end

	// ----------------------------------------------------------------
	// Baud timing
	// ----------------------------------------------------------------
	// Sub-ticks per bit come from the multiplier; half-bit used for 1.5 stop.
	uatx_state_t state_q;
	logic running;
	logic sub_tick;
	logic [4:0] sub_q;
	logic [3:0] bit_q;
	logic half_q;

	wire [4:0] ticks_per_bit = baud_multiplier_bit ? `UATX_TICKS_HIGH : `UATX_TICKS_NORMAL;
	wire [4:0] half_ticks = {1'b0, ticks_per_bit[4:1]};

	assign running = periph_on && transmit_enable_bit;

	// Bits are timed only while a frame runs, so every start bit gets a full period
	uatx_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.mclk(mclk),
		.rst_b(rst_b),
		.run(running && (state_q != UATX_IDLE)),
		.divisor(baud_q),
		.tick(sub_tick)
	);

	wire bit_end = sub_tick && (sub_q == ticks_per_bit - 5'd1);
	wire half_end = sub_tick && (sub_q == half_ticks - 5'd1);

	// ----------------------------------------------------------------
	// Frame format
	// ----------------------------------------------------------------
	function automatic logic has_ninth(input logic [3:0] m);
		has_ninth = (m != `UATX_MODE_8BIT) && (m != `UATX_MODE_7BIT);
	endfunction

	logic [7:0] shifter_q; // transmit_shifter, not readable by software
	logic ninth_q;
	logic line_q;
	logic [1:0] stop_cnt_q;

	wire [3:0] data_bits = (mode == `UATX_MODE_7BIT) ? 4'd7 : 4'd8;
	// Parity comes from the buffer at load time, so later writes cannot disturb it
	wire par_even = ^transmit_buffer_reg_q;
	// Address mode marks the ninth bit; software picks frames by a control bit
	wire addr_mark = control_reg_two_q[3];
	logic ninth_d;
	always_comb begin
		case (mode)
			`UATX_MODE_EVEN: ninth_d = par_even;
			`UATX_MODE_ODD: ninth_d = ~par_even;
			default: ninth_d = addr_mark;
		endcase
	end

	wire [1:0] stop_whole = (stop_sel == 2'(UATX_STOP_1)) ? 2'd1 : 2'd2;
	wire stop_half = (stop_sel == 2'(UATX_STOP_1P5));

	wire in_stop_first = (state_q == UATX_STOP) && (stop_cnt_q == 2'd0) && !half_q;
	wire stop_done = (state_q == UATX_STOP) &&
		((half_q && half_end) || (!half_q && bit_end && stop_cnt_q == stop_whole - 2'd1 &&
		!stop_half));
	wire stop_to_half = (state_q == UATX_STOP) && !half_q && bit_end && stop_half;

	// Shifter takes the buffer when idle, or at the start of the stop bit
	wire load_idle = (state_q == UATX_IDLE) && buf_full_q && running;
	logic loaded_q; // next character already in shifter
	wire load_stop = in_stop_first && buf_full_q && !loaded_q && running;
	// A write that lands before the last stop bit ends, but after the first stop bit,
	// goes straight into the next frame: no idle gap and no stale queued copy
	wire load_late = stop_done && buf_full_q && !loaded_q;
	wire load_now = load_idle || load_stop || load_late;

	// ----------------------------------------------------------------
	// Transmit buffer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			transmit_buffer_reg_q <= 8'h00;
			buf_full_q <= 1'b0;
		end else if (wr_txbuf && (!buf_full_q || load_now)) begin
			transmit_buffer_reg_q <= reg_wdata;
			buf_full_q <= 1'b1;
		end else if (load_now) begin
			buf_full_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	logic [7:0] next_shift_q;
	logic next_ninth_q;
	// Character and ninth bit that a back-to-back frame starts with
	wire [7:0] next_char = loaded_q ? next_shift_q : transmit_buffer_reg_q;
	wire next_bit9 = loaded_q ? next_ninth_q : ninth_d;
	// Dropping enable or on aborts the frame; a character queued in the shifter stage is lost

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= UATX_IDLE;
			sub_q <= 5'd0;
			bit_q <= 4'd0;
			half_q <= 1'b0;
			stop_cnt_q <= 2'd0;
			shifter_q <= 8'h00;
			ninth_q <= 1'b0;
			loaded_q <= 1'b0;
			next_shift_q <= 8'h00;
			next_ninth_q <= 1'b0;
		end else if (!running) begin
			state_q <= UATX_IDLE;
			sub_q <= 5'd0;
			loaded_q <= 1'b0;
		end else begin
			if (sub_tick) sub_q <= bit_end ? 5'd0 : sub_q + 5'd1;
			if (load_stop) begin
				next_shift_q <= transmit_buffer_reg_q;
				next_ninth_q <= ninth_d;
				loaded_q <= 1'b1;
			end
			case (state_q)
				UATX_IDLE: begin
					sub_q <= 5'd0;
					if (load_idle) begin
						shifter_q <= transmit_buffer_reg_q;
						ninth_q <= ninth_d;
						state_q <= UATX_START;
					end
				end
				UATX_START: begin
					if (bit_end) begin
						bit_q <= 4'd0;
						state_q <= UATX_DATA;
					end
				end
				UATX_DATA: begin
					if (bit_end) begin
						shifter_q <= {1'b0, shifter_q[7:1]};
						bit_q <= bit_q + 4'd1;
						if (bit_q == data_bits - 4'd1) begin
							state_q <= has_ninth(mode) ? UATX_NINTH : UATX_STOP;
							stop_cnt_q <= 2'd0;
							half_q <= 1'b0;
						end
					end
				end
				UATX_NINTH: begin
					if (bit_end) begin
						state_q <= UATX_STOP;
						stop_cnt_q <= 2'd0;
						half_q <= 1'b0;
					end
				end
				UATX_STOP: begin
					if (stop_to_half) begin
						half_q <= 1'b1;
						sub_q <= 5'd0;
					end else if (stop_done) begin
						half_q <= 1'b0;
						sub_q <= 5'd0;
						if (loaded_q || load_late) begin
							shifter_q <= next_char;
							ninth_q <= next_bit9;
							loaded_q <= 1'b0;
							state_q <= UATX_START;
						end else begin
							state_q <= UATX_IDLE;
						end
					end else if (bit_end) begin
						stop_cnt_q <= stop_cnt_q + 2'd1;
					end
				end
				default: state_q <= UATX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Line level and pin
	// ----------------------------------------------------------------
	always_comb begin
		case (state_q)
			UATX_START: line_q = 1'b0;
			UATX_DATA: line_q = shifter_q[0];
			UATX_NINTH: line_q = ninth_q;
			default: line_q = 1'b1;
		endcase
	end

	// Polarity applied after the sequencer so a change shows at once
	assign tx_internal = line_q ^ transmit_polarity_bit;
	wire busy = running && (state_q != UATX_IDLE);
	// Keep the line when the direction control says output, else drive only while busy
	assign tx_pin_oe = busy || !port_direction_control;
	// Internal consumers see the same serial stream as the pin
	assign tx_pin_o = tx_internal;
	// The port latch matters only once the pin is released, outside this block
	wire unused_latch = port_out_latch;

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Empty drops as soon as the buffer fills, one cycle ahead of the load,
	// so software polling it never sees a gap between write and start
	assign transmit_buffer_free_flag = transmit_enable_bit && !buf_full_q;
	assign shifter_empty_flag = (state_q == UATX_IDLE) && !buf_full_q;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			ADDR_W'(`UATX_OFF_CTRL0): rd_mux = control_reg_zero_q;
			ADDR_W'(`UATX_OFF_CTRL1): rd_mux = control_reg_one_q;
			ADDR_W'(`UATX_OFF_CTRL2): rd_mux = control_reg_two_q;
			ADDR_W'(`UATX_OFF_BAUDL): rd_mux = baud_q[7:0];
			ADDR_W'(`UATX_OFF_BAUDH): rd_mux = baud_q[DIV_W-1:8];
			ADDR_W'(`UATX_OFF_STAT): rd_mux = {6'h00, shifter_empty_flag,
				transmit_buffer_free_flag};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_rd ? (rd_mux | {7'h00, 1'b0 & unused_latch}) : 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
endmodule

`default_nettype wire

// file: logic/uatx_params.svh
`ifndef UATX_PARAMS_SVH
`define UATX_PARAMS_SVH

// Register offsets on the plain register port
`define UATX_OFF_CTRL0 4'h0
`define UATX_OFF_CTRL1 4'h1
`define UATX_OFF_CTRL2 4'h2
`define UATX_OFF_BAUDL 4'h3
`define UATX_OFF_BAUDH 4'h4
`define UATX_OFF_TXBUF 4'h5
`define UATX_OFF_STAT 4'h6

// Field positions
`define UATX_C0_TRANSMIT_ENABLE_BIT 5
`define UATX_C0_BRGS 7
`define UATX_C1_ON 7
`define UATX_C2_TRANSMIT_POLARITY_BIT 2
`define UATX_C2_STP_LO 0
`define UATX_ST_TXIF 0
`define UATX_ST_TXMT 1

// Mode codes
`define UATX_MODE_8BIT 4'h0
`define UATX_MODE_7BIT 4'h1
`define UATX_MODE_ODD 4'h2
`define UATX_MODE_EVEN 4'h3

// Reset values
`define UATX_RST_CTRL0 8'h00
`define UATX_RST_CTRL1 8'h00
`define UATX_RST_CTRL2 8'h00
`define UATX_RST_BAUD 16'h0000

// Baud ticks per bit for normal and high speed
`define UATX_TICKS_NORMAL 5'd16
`define UATX_TICKS_HIGH 5'd4

`endif

// file: logic/uatx_pkg.sv
`default_nettype none

package uatx_pkg;
	typedef enum logic [2:0] {
		UATX_IDLE,
		UATX_START,
		UATX_DATA,
		UATX_NINTH,
		UATX_STOP
	} uatx_state_t;

	typedef enum logic [1:0] {
		UATX_STOP_1,
		UATX_STOP_1P5,
		UATX_STOP_2,
		UATX_STOP_2B
	} uatx_stop_t;
endpackage

`default_nettype wire

// file: logic/uatx_baud_gen.sv
`default_nettype none
`include "uatx_params.svh"

// Divides mclk by (divisor + 1) and emits a one-cycle tick per baud sub-period.
module uatx_baud_gen #(
	parameter int DIV_W = 16
) (
	input wire logic mclk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic run, // counts while high
	input wire logic [DIV_W-1:0] divisor, // reload value
	output logic tick // one-cycle sub-period pulse
);
	logic [DIV_W-1:0] cnt_q;
	wire cnt_zero = (cnt_q == '0);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (!run || cnt_zero) begin
			cnt_q <= divisor;
		end else begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign tick = run && cnt_zero;
endmodule

`default_nettype wire

// file: dv/uatx_chk.sv
`default_nettype none
`include "uatx_params.svh"
module uatx_chk #(
	parameter int ADDR_W = 4
) (
	input wire logic mclk, // clock
	input wire logic rst_b, // reset
	input wire logic [ADDR_W-1:0] reg_addr, // address
	input wire logic reg_wr, // write strobe
	input wire logic port_direction_control, // pin direction
	input wire logic tx_pin_o, // pin level
	input wire logic tx_pin_oe, // pin enable
	input wire logic tx_internal, // internal copy
	input wire logic transmit_buffer_free_flag, // buffer free
	input wire logic shifter_empty_flag, // shifter idle
	input wire logic [3:0] mode_code // shared format
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	wire buf_wr = reg_wr && reg_addr == `UATX_OFF_TXBUF;
	wire c0_wr = reg_wr && reg_addr == `UATX_OFF_CTRL0;
	a_internal_copy: assert property (tx_internal == tx_pin_o)
		else $error("internal output differs from pin");
	a_busy_drives: assert property (!shifter_empty_flag && transmit_buffer_free_flag
		|-> tx_pin_oe)
		else $error("pin not driven during frame");
	a_dir_keeps: assert property (!port_direction_control |-> tx_pin_oe)
		else $error("pin released with direction cleared");
	a_idle_releases: assert property (shifter_empty_flag && port_direction_control |-> !tx_pin_oe)
		else $error("idle pin still driven");
	a_idle_still: assert property (shifter_empty_flag && $past(shifter_empty_flag) && !$past(reg_wr)
		|-> $stable(tx_pin_o))
		else $error("idle line moved");
	a_write_starts: assert property (buf_wr && shifter_empty_flag && transmit_buffer_free_flag
		|=> !shifter_empty_flag ##1 tx_pin_o != $past(tx_pin_o, 2))
		else $error("write to idle shifter did not start");
	a_queued_holds: assert property (buf_wr && !shifter_empty_flag && transmit_buffer_free_flag
		|=> !transmit_buffer_free_flag)
		else $error("queued character not held");
	a_mode_shared: assert property (!c0_wr |=> $stable(mode_code))
		else $error("format changed without write");
endmodule
bind uatx_top uatx_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .port_direction_control(port_direction_control),
	.tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_internal(tx_internal),
	.transmit_buffer_free_flag(transmit_buffer_free_flag),
	.shifter_empty_flag(shifter_empty_flag), .mode_code(mode_code));
`default_nettype wire

// file: dv/uatx_rx_model.sv
`default_nettype none
module uatx_rx_model (
	input wire logic mclk, // clock
	input wire logic line, // serial line
	input wire logic pol, // inverted line
	input wire logic [7:0] bit_cyc, // clocks per bit
	input wire logic [3:0] nbits, // data bits
	input wire logic ninth_en, // ninth bit present
	output logic [7:0] rx_data, // last data
	output logic rx_ninth, // last ninth bit
	output logic rx_ok, // start and stop right
	output var int rx_frames, // frames seen
	output var int rx_gap // clocks between starts
);
	timeunit 1ns;
	timeprecision 1ns;
	time last_t = 0;
	initial begin
		rx_frames = 0;
		rx_gap = 0;
	end
	// Falling edge sampling keeps clear of the launch edge
	always begin
		@(negedge mclk);
		if ((line ^ pol) === 1'b0) begin
			rx_gap = int'(($time - last_t) / 10);
			last_t = $time;
			repeat (bit_cyc / 2) @(negedge mclk);
			rx_ok = (line ^ pol) === 1'b0;
			rx_data = 8'h00;
			rx_ninth = 1'b0;
			for (int i = 0; i < nbits; i++) begin
				repeat (bit_cyc) @(negedge mclk);
				rx_data[i] = line ^ pol;
			end
			if (ninth_en) begin
				repeat (bit_cyc) @(negedge mclk);
				rx_ninth = line ^ pol;
			end
			repeat (bit_cyc) @(negedge mclk);
			rx_ok = rx_ok && (line ^ pol) === 1'b1;
			rx_frames++;
		end
	end
endmodule
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
`include "uatx_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0;
	logic rst_b = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic dir = 0;
	logic pol_m = 0;
	logic nin = 0;
	logic [3:0] reg_addr = 0;
	logic [3:0] nb = 8;
	logic [7:0] reg_wdata = 0;
	logic [7:0] bc = 32;
	logic [7:0] reg_rdata;
	logic [7:0] rx_data;
	logic [3:0] mode_o;
	logic [15:0] baud_o;
	logic mult_o;
	logic tx_pin_o, tx_pin_oe, tx_internal, buf_free, sh_empty, rx_ninth, rx_ok;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'hba298e05;
	int rx_frames, rx_gap;
	// Pull-up on the pin while nobody drives it
	wire tx_line = tx_pin_oe ? tx_pin_o : 1'b1;
	always #5 mclk = ~mclk;
	uatx_top #(.DIV_W(16), .ADDR_W(4)) DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_direction_control(dir), .port_out_latch(1'b0), .tx_pin_o(tx_pin_o),
		.tx_pin_oe(tx_pin_oe), .tx_internal(tx_internal), .transmit_buffer_free_flag(buf_free),
		.shifter_empty_flag(sh_empty), .mode_code(mode_o), .baud_divisor_pair(baud_o),
		.baud_multiplier_bit(mult_o));
	uatx_rx_model rx (.mclk(mclk), .line(tx_line), .pol(pol_m), .bit_cyc(bc), .nbits(nb),
		.ninth_en(nin), .rx_data(rx_data), .rx_ninth(rx_ninth), .rx_ok(rx_ok),
		.rx_frames(rx_frames), .rx_gap(rx_gap));
	function automatic logic [7:0] exp_data(input logic [3:0] m, input logic [7:0] d);
		return (m == 4'h1) ? {1'b0, d[6:0]} : d;
	endfunction
	function automatic logic exp_ninth(input logic [3:0] m, input logic [7:0] d, input logic a);
		return (m == 4'h3) ? ^d : (m == 4'h2) ? ~^d : (m > 4'h3) ? a : 1'b0;
	endfunction
	function automatic logic [15:0] exp_gap(input logic [3:0] m, input int s, input int b);
		int bits = (m == 4'h1) ? 8 : (m > 4'h1) ? 10 : 9;
		return 16'(bits * b + (s + 2) * b / 2);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_rd <= 0;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge mclk);
	endtask
	task automatic idle(input int n);
		reg_wr <= 0;
		reg_rd <= 0;
		repeat (n) @(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		reg_wr <= 0;
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge mclk);
		reg_rd <= 0;
		@(negedge mclk);
		chk(reg_rdata, exp);
		@(posedge mclk);
	endtask
	task automatic wait_frames(input int n);
		int k = 0;
		idle(0);
		while (rx_frames < n && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		if (k == 3000) begin
			fails++;
			$display("[FAIL] %0t no frame arrived", $time);
			complete_run();
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			complete_run();
		end
	end
	initial begin
		logic [7:0] d[2];
		logic [3:0] m;
		logic ad;
		repeat (20) @(posedge mclk);
		rst_b <= 1;
		@(posedge mclk);
		rd(`UATX_OFF_STAT, 8'h02);
		rd(4'hf, 8'h00);
		chk(tx_line, 1);
		for (int c = 0; c < 5; c++) begin
			m = (c == 4) ? 4'h4 : 4'(c);
			ad = 1'($random(seed));
			nb <= (m == 4'h1) ? 4'd7 : 4'd8;
			nin <= m > 4'h1;
			bc <= (c == 4) ? 8'd8 : 8'd32;
			wr(`UATX_OFF_BAUDL, 8'h01);
			wr(`UATX_OFF_BAUDH, 8'h00);
			wr(`UATX_OFF_CTRL0, {c == 4, 2'b01, 1'b0, m});
			wr(`UATX_OFF_CTRL2, {4'h0, ad, c == 2, 2'(c % 3)});
			pol_m <= c == 2;
			wr(`UATX_OFF_CTRL1, 8'h80);
			idle(2);
			chk(mode_o, m);
			chk(baud_o, 16'h0001);
			chk(mult_o, c == 4);
			d[0] = 8'($random(seed));
			d[1] = (c == 1) ? 8'hff : 8'($random(seed));
			wr(`UATX_OFF_TXBUF, d[0]);
			if (c % 2 == 0) idle(1);
			wr(`UATX_OFF_TXBUF, d[1]);
			rd(`UATX_OFF_STAT, 8'h00);
			for (int f = 0; f < 2; f++) begin
				wait_frames(2 * c + f + 1);
				chk(rx_data, exp_data(m, d[f]));
				chk(rx_ninth, exp_ninth(m, d[f], ad));
				chk(rx_ok, 1);
			end
			chk(16'(rx_gap), exp_gap(m, c % 3, int'(bc)));
			idle(2 * bc);
			rd(`UATX_OFF_STAT, 8'h03);
			$display("test mode %0d done", m);
		end
		dir <= 1;
		idle(2);
		chk(tx_pin_oe, 0);
		wr(`UATX_OFF_TXBUF, 8'($random(seed)));
		idle(20);
		chk(tx_pin_oe, 1);
		wr(`UATX_OFF_CTRL0, 8'h00);
		idle(3);
		chk(tx_pin_o, 1);
		chk(sh_empty, 1);
		wr(`UATX_OFF_CTRL1, 8'h00);
		wr(`UATX_OFF_CTRL2, 8'h04);
		idle(0);
		@(negedge mclk);
		chk(tx_pin_o, 0);
		chk(tx_internal, 0);
		@(posedge mclk);
		$display("test pin control done");
		complete_run();
	end
endmodule
`default_nettype wire
